// [port_mux_consts.svh]
`ifndef PORT_MUX_CONSTS_SVH
`define PORT_MUX_CONSTS_SVH

// Register offsets.
`define ADDR_P3_HYST 16'h5234
`define ADDR_P3_GATE 16'h523a
`define ADDR_P0_SEL 16'h52a0
`define ADDR_P1_SEL 16'h52a1
`define ADDR_P2_SEL 16'h52a2
`define ADDR_P3_SEL 16'h52a3

// Reset values and implemented-bit masks.
`define RST_P3_HYST 8'hff
`define RST_P3_GATE 8'hff
`define RST_SEL 8'h00
`define MASK_P3 8'h0f
`define MASK_P0_SEL 8'h3c
`define MASK_FULL 8'hff

// Field positions.
`define P0_TMR4N 5
`define P0_TMR4 4
`define P0_RMT_TX 3
`define P0_RMT_RX 2
`define P1_SS 7
`define P1_TMR5 6
`define P1_SCL 5
`define P1_SDA 4
`define P1_CLKO1 3
`define P1_S1_CLK 2
`define P1_S1_TX 1
`define P1_S1_RX 0
`define P2_TMR3N 7
`define P2_TMR3 6
`define P2_S0_CLK 5
`define P2_S0_TX 4
`define P2_S0_RX 3
`define P2_SPI_CLK 2
`define P2_SPI_DO 1
`define P2_SPI_DI 0
`define P3_DBG_IO 3
`define P3_DBG_ST 2
`define P3_DBG_CLK 1
`define P3_HSCLK 0
`endif

// [port_mux_pkg.sv]
package port_mux_pkg;
    typedef logic [15:0] addr_type;
    typedef logic [7:0] byte_type;
    // One-hot register select produced by the address decoder.
    typedef enum logic [6:0] {
        SEL_NONE = 7'h01,
        SEL_P3_HYST = 7'h02,
        SEL_P3_GATE = 7'h04,
        SEL_P0 = 7'h08,
        SEL_P1 = 7'h10,
        SEL_P2 = 7'h20,
        SEL_P3 = 7'h40
    } reg_sel_type;
endpackage

// [mux_ctrl_reg.sv]
module mux_ctrl_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] MASK = 8'hff
) (
    input wire logic clk_sys, // System clock.
    input wire logic resetn, // Async reset, active low.
    input wire logic clk_en, // Freezes state when low.
    input wire logic wr_en, // Write this register.
    input wire port_mux_pkg::byte_type wr_data, // Write data.
    output port_mux_pkg::byte_type value_reg // Stored value.
);
    import port_mux_pkg::*;

    // A register with no implemented bit cannot serve anything.
    if (MASK == 8'h00) begin : g_bad_mask
        $error("mux_ctrl_reg needs at least one implemented bit.");
    end

    // Unimplemented bits are held at zero so they read as zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            value_reg <= RESET_VALUE & MASK;
        end else if (clk_en && wr_en) begin
            value_reg <= wr_data & MASK;
        end
    end
endmodule

// [pin_mux_cell.sv]
module pin_mux_cell #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic [WIDTH-1:0] sel, // 1 gives the pin to the peripheral.
    input wire logic [WIDTH-1:0] gpio_out, // Port output data.
    input wire logic [WIDTH-1:0] gpio_oe, // Port output enable.
    input wire logic [WIDTH-1:0] per_out, // Peripheral output data.
    input wire logic [WIDTH-1:0] per_oe, // Peripheral output enable.
    input wire logic [WIDTH-1:0] pad_in, // Level seen at the pad.
    output logic [WIDTH-1:0] pad_out, // Level driven to the pad.
    output logic [WIDTH-1:0] pad_oe, // Pad driver enable.
    output logic [WIDTH-1:0] gpio_in, // Pin level for the port.
    output logic [WIDTH-1:0] per_in // Pin level for the peripheral.
);
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_mux_cell needs at least one pin.");
    end

    // The owner of each pin drives it; the other side has no effect.
    assign pad_out = (sel & per_out) | (~sel & gpio_out);
    assign pad_oe = (sel & per_oe) | (~sel & gpio_oe);
    // The port always sees the pin; an unselected peripheral sees idle.
    assign gpio_in = pad_in;
    assign per_in = (sel & pad_in) | (~sel & IDLE);
endmodule

// [port_pin_function_mux.sv]
`include "port_mux_consts.svh"

module port_pin_function_mux #(
    parameter int ADDR_WIDTH = 16
) (
    input wire logic clk_sys, // 100 MHz clock.
    input wire logic resetn, // Async reset, active low.
    input wire logic clk_en, // Freezes state when low.
    input wire port_mux_pkg::addr_type reg_addr, // Register address.
    input wire port_mux_pkg::byte_type reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    output port_mux_pkg::byte_type reg_rdata, // Read data, next cycle.
    input wire logic [7:0] p0_pad_in, // Port 0 pad level.
    output logic [7:0] p0_pad_out, // Port 0 pad drive.
    output logic [7:0] p0_pad_oe, // Port 0 pad enable.
    input wire logic [7:0] p0_gpio_out, // Port 0 data.
    input wire logic [7:0] p0_gpio_oe, // Port 0 enable.
    output logic [7:0] p0_gpio_in, // Port 0 input.
    input wire logic [7:0] p1_pad_in, // Port 1 pad level.
    output logic [7:0] p1_pad_out, // Port 1 pad drive.
    output logic [7:0] p1_pad_oe, // Port 1 pad enable.
    input wire logic [7:0] p1_gpio_out, // Port 1 data.
    input wire logic [7:0] p1_gpio_oe, // Port 1 enable.
    output logic [7:0] p1_gpio_in, // Port 1 input.
    input wire logic [7:0] p2_pad_in, // Port 2 pad level.
    output logic [7:0] p2_pad_out, // Port 2 pad drive.
    output logic [7:0] p2_pad_oe, // Port 2 pad enable.
    input wire logic [7:0] p2_gpio_out, // Port 2 data.
    input wire logic [7:0] p2_gpio_oe, // Port 2 enable.
    output logic [7:0] p2_gpio_in, // Port 2 input.
    input wire logic [3:0] p3_pad_in, // Port 3 pad level.
    output logic [3:0] p3_pad_out, // Port 3 pad drive.
    output logic [3:0] p3_pad_oe, // Port 3 pad enable.
    input wire logic [3:0] p3_gpio_out, // Port 3 data.
    input wire logic [3:0] p3_gpio_oe, // Port 3 enable.
    output logic [3:0] p3_gpio_in, // Port 3 gated input.
    output logic [3:0] p3_schmitt_en, // 1 selects Schmitt input.
    input wire logic timer_ch4_inverted_out, // Timer 4 inverted.
    input wire logic timer_ch4_out, // Timer 4 output.
    input wire logic remote_tx_out, // Remote transmitter.
    output logic remote_rx_in, // Remote receiver.
    input wire logic spi_slave_select_n_drv, // SPI select drive.
    input wire logic spi_slave_select_n_oe, // SPI select enable.
    output logic spi_slave_select_n, // SPI select level.
    input wire logic timer_ch5_out, // Timer 5 output.
    output logic external_clock_in_0, // External clock 0.
    input wire logic i2c_scl_drv, // SCL drive.
    input wire logic i2c_scl_oe, // SCL enable.
    output logic i2c_scl_in, // SCL level.
    input wire logic i2c_sda_drv, // SDA drive.
    input wire logic i2c_sda_oe, // SDA enable.
    output logic i2c_sda_in, // SDA level.
    input wire logic clock_out_ch1, // Clock output 1.
    input wire logic serial1_clock_drv, // Serial 1 clock drive.
    input wire logic serial1_clock_oe, // Serial 1 clock enable.
    output logic serial1_clock, // Serial 1 clock level.
    input wire logic serial1_tx, // Serial 1 transmit.
    output logic serial1_rx, // Serial 1 receive.
    input wire logic timer_ch3_inverted_out, // Timer 3 inverted.
    input wire logic timer_ch3_out, // Timer 3 output.
    input wire logic serial0_clock_drv, // Serial 0 clock drive.
    input wire logic serial0_clock_oe, // Serial 0 clock enable.
    output logic serial0_clock, // Serial 0 clock level.
    input wire logic serial0_tx, // Serial 0 transmit.
    output logic serial0_rx, // Serial 0 receive.
    input wire logic spi_serial_clock_drv, // SPI clock drive.
    input wire logic spi_serial_clock_oe, // SPI clock enable.
    output logic spi_serial_clock, // SPI clock level.
    input wire logic spi_data_out, // SPI data out.
    output logic spi_data_in, // SPI data in.
    input wire logic debug_serial_io_drv, // Debug data drive.
    input wire logic debug_serial_io_oe, // Debug data enable.
    output logic debug_serial_io, // Debug data level.
    input wire logic debug_status, // Debug status.
    input wire logic high_speed_clock_out, // High-speed clock output.
    output logic debug_clock // Debug clock.
);
    import port_mux_pkg::*;

    if (ADDR_WIDTH != 16) begin : g_bad_addr
        $error("port_pin_function_mux needs a 16-bit address.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    byte_type hyst_reg, gate_reg, p0_sel_reg, p1_sel_reg, p2_sel_reg, p3_sel_reg;
    byte_type rdata_reg, rdata_next;
    reg_sel_type wr_sel, rd_sel;

    // Maps an address onto the one-hot register select.
    function automatic reg_sel_type decode(input addr_type addr);
        case (addr)
            `ADDR_P3_HYST: decode = SEL_P3_HYST;
            `ADDR_P3_GATE: decode = SEL_P3_GATE;
            `ADDR_P0_SEL: decode = SEL_P0;
            `ADDR_P1_SEL: decode = SEL_P1;
            `ADDR_P2_SEL: decode = SEL_P2;
            `ADDR_P3_SEL: decode = SEL_P3;
            default: decode = SEL_NONE;
        endcase
    endfunction

    assign wr_sel = reg_wr ? decode(reg_addr) : SEL_NONE;
    assign rd_sel = decode(reg_addr);

    // Hysteresis and input gate come out of reset with all four implemented bits set.
    mux_ctrl_reg #(.RESET_VALUE(`RST_P3_HYST), .MASK(`MASK_P3)) u_hyst (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .wr_en(wr_sel == SEL_P3_HYST), .wr_data(reg_wdata), .value_reg(hyst_reg));
    mux_ctrl_reg #(.RESET_VALUE(`RST_P3_GATE), .MASK(`MASK_P3)) u_gate (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .wr_en(wr_sel == SEL_P3_GATE), .wr_data(reg_wdata), .value_reg(gate_reg));
    // Select registers reset to zero and keep only implemented bits.
    mux_ctrl_reg #(.RESET_VALUE(`RST_SEL), .MASK(`MASK_P0_SEL)) u_p0 (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .wr_en(wr_sel == SEL_P0), .wr_data(reg_wdata), .value_reg(p0_sel_reg));
    mux_ctrl_reg #(.RESET_VALUE(`RST_SEL), .MASK(`MASK_FULL)) u_p1 (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .wr_en(wr_sel == SEL_P1), .wr_data(reg_wdata), .value_reg(p1_sel_reg));
    mux_ctrl_reg #(.RESET_VALUE(`RST_SEL), .MASK(`MASK_FULL)) u_p2 (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .wr_en(wr_sel == SEL_P2), .wr_data(reg_wdata), .value_reg(p2_sel_reg));
    mux_ctrl_reg #(.RESET_VALUE(`RST_SEL), .MASK(`MASK_P3)) u_p3 (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .wr_en(wr_sel == SEL_P3), .wr_data(reg_wdata), .value_reg(p3_sel_reg));

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        case (rd_sel)
            SEL_P3_HYST: rdata_next = hyst_reg;
            SEL_P3_GATE: rdata_next = gate_reg;
            SEL_P0: rdata_next = p0_sel_reg;
            SEL_P1: rdata_next = p1_sel_reg;
            SEL_P2: rdata_next = p2_sel_reg;
            SEL_P3: rdata_next = p3_sel_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stand for one enabled cycle after the strobe, then clear to zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            rdata_reg <= reg_rd ? rdata_next : 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Port 0: timer 4 and remote control.

    logic [7:0] p0_per_out, p0_per_oe, p0_per_in;
    logic [7:0] p1_per_out, p1_per_oe, p1_per_in;
    logic [7:0] p2_per_out, p2_per_oe, p2_per_in;
    logic [3:0] p3_per_out, p3_per_oe, p3_per_in, p3_sel, p3_pad_gated;

    // Collects the port 0 peripheral drivers.
    always_comb begin
        p0_per_out = 8'h00;
        p0_per_oe = 8'h00;
        p0_per_out[`P0_TMR4N] = timer_ch4_inverted_out;
        p0_per_oe[`P0_TMR4N] = 1'b1;
        p0_per_out[`P0_TMR4] = timer_ch4_out;
        p0_per_oe[`P0_TMR4] = 1'b1;
        p0_per_out[`P0_RMT_TX] = remote_tx_out;
        p0_per_oe[`P0_RMT_TX] = 1'b1;
    end

    pin_mux_cell #(.WIDTH(8), .IDLE(8'h00)) u_cell0 (
        .sel(p0_sel_reg), .gpio_out(p0_gpio_out), .gpio_oe(p0_gpio_oe),
        .per_out(p0_per_out), .per_oe(p0_per_oe), .pad_in(p0_pad_in),
        .pad_out(p0_pad_out), .pad_oe(p0_pad_oe), .gpio_in(p0_gpio_in),
        .per_in(p0_per_in));

    assign remote_rx_in = p0_per_in[`P0_RMT_RX];

    ////////////////////////////////////////////////////////////////////////
    // Port 1: SPI select, timer 5, I2C, clock out 1, serial 1.

    // Collects the port 1 peripheral drivers.
    always_comb begin
        p1_per_out = 8'h00;
        p1_per_oe = 8'h00;
        p1_per_out[`P1_SS] = spi_slave_select_n_drv;
        p1_per_oe[`P1_SS] = spi_slave_select_n_oe;
        p1_per_out[`P1_TMR5] = timer_ch5_out;
        p1_per_oe[`P1_TMR5] = 1'b1;
        p1_per_out[`P1_SCL] = i2c_scl_drv;
        p1_per_oe[`P1_SCL] = i2c_scl_oe;
        p1_per_out[`P1_SDA] = i2c_sda_drv;
        p1_per_oe[`P1_SDA] = i2c_sda_oe;
        p1_per_out[`P1_CLKO1] = clock_out_ch1;
        p1_per_oe[`P1_CLKO1] = 1'b1;
        p1_per_out[`P1_S1_CLK] = serial1_clock_drv;
        p1_per_oe[`P1_S1_CLK] = serial1_clock_oe;
        p1_per_out[`P1_S1_TX] = serial1_tx;
        p1_per_oe[`P1_S1_TX] = 1'b1;
    end

    // Idle high on the select and I2C lines, which are released high.
    pin_mux_cell #(.WIDTH(8), .IDLE(8'hb0)) u_cell1 (
        .sel(p1_sel_reg), .gpio_out(p1_gpio_out), .gpio_oe(p1_gpio_oe),
        .per_out(p1_per_out), .per_oe(p1_per_oe), .pad_in(p1_pad_in),
        .pad_out(p1_pad_out), .pad_oe(p1_pad_oe), .gpio_in(p1_gpio_in),
        .per_in(p1_per_in));

    // Peripheral inputs of port 1.
    assign spi_slave_select_n = p1_per_in[`P1_SS];
    assign i2c_scl_in = p1_per_in[`P1_SCL];
    assign i2c_sda_in = p1_per_in[`P1_SDA];
    assign serial1_clock = p1_per_in[`P1_S1_CLK];
    assign serial1_rx = p1_per_in[`P1_S1_RX];
    // The external clock shares the pin while it is a port pin.
    assign external_clock_in_0 = p1_pad_in[`P1_TMR5] & ~p1_sel_reg[`P1_TMR5];

    ////////////////////////////////////////////////////////////////////////
    // Port 2: timer 3, serial 0, SPI.

    // Collects the port 2 peripheral drivers.
    always_comb begin
        p2_per_out = 8'h00;
        p2_per_oe = 8'h00;
        p2_per_out[`P2_TMR3N] = timer_ch3_inverted_out;
        p2_per_oe[`P2_TMR3N] = 1'b1;
        p2_per_out[`P2_TMR3] = timer_ch3_out;
        p2_per_oe[`P2_TMR3] = 1'b1;
        p2_per_out[`P2_S0_CLK] = serial0_clock_drv;
        p2_per_oe[`P2_S0_CLK] = serial0_clock_oe;
        p2_per_out[`P2_S0_TX] = serial0_tx;
        p2_per_oe[`P2_S0_TX] = 1'b1;
        p2_per_out[`P2_SPI_CLK] = spi_serial_clock_drv;
        p2_per_oe[`P2_SPI_CLK] = spi_serial_clock_oe;
        p2_per_out[`P2_SPI_DO] = spi_data_out;
        p2_per_oe[`P2_SPI_DO] = 1'b1;
    end

    pin_mux_cell #(.WIDTH(8), .IDLE(8'h00)) u_cell2 (
        .sel(p2_sel_reg), .gpio_out(p2_gpio_out), .gpio_oe(p2_gpio_oe),
        .per_out(p2_per_out), .per_oe(p2_per_oe), .pad_in(p2_pad_in),
        .pad_out(p2_pad_out), .pad_oe(p2_pad_oe), .gpio_in(p2_gpio_in),
        .per_in(p2_per_in));

    // Peripheral inputs of port 2.
    assign serial0_clock = p2_per_in[`P2_S0_CLK];
    assign serial0_rx = p2_per_in[`P2_S0_RX];
    assign spi_serial_clock = p2_per_in[`P2_SPI_CLK];
    assign spi_data_in = p2_per_in[`P2_SPI_DI];

    ////////////////////////////////////////////////////////////////////////
    // Port 3: debug port, high-speed clock, input conditioning.

    // Debug bits are inverted: zero gives the pin to the debugger.
    assign p3_sel = {~p3_sel_reg[3:1], p3_sel_reg[0]};
    // A cleared gate bit blocks the pin's input everywhere.
    assign p3_pad_gated = p3_pad_in & gate_reg[3:0];
    assign p3_schmitt_en = hyst_reg[3:0];

    // Collects the port 3 peripheral drivers.
    always_comb begin
        p3_per_out = 4'h0;
        p3_per_oe = 4'h0;
        p3_per_out[`P3_DBG_IO] = debug_serial_io_drv;
        p3_per_oe[`P3_DBG_IO] = debug_serial_io_oe;
        p3_per_out[`P3_DBG_ST] = debug_status;
        p3_per_oe[`P3_DBG_ST] = 1'b1;
        p3_per_out[`P3_HSCLK] = high_speed_clock_out;
        p3_per_oe[`P3_HSCLK] = 1'b1;
    end

    pin_mux_cell #(.WIDTH(4), .IDLE(4'h0)) u_cell3 (
        .sel(p3_sel), .gpio_out(p3_gpio_out), .gpio_oe(p3_gpio_oe),
        .per_out(p3_per_out), .per_oe(p3_per_oe), .pad_in(p3_pad_gated),
        .pad_out(p3_pad_out), .pad_oe(p3_pad_oe), .gpio_in(p3_gpio_in),
        .per_in(p3_per_in));

    // Peripheral inputs of port 3.
    assign debug_serial_io = p3_per_in[`P3_DBG_IO];
    assign debug_clock = p3_per_in[`P3_DBG_CLK];

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_hyst_write;
        clk_en && reg_wr && reg_addr == `ADDR_P3_HYST
            |=> p3_schmitt_en == $past(reg_wdata[3:0]) && reg_rdata[7:4] == 4'h0;
    endproperty
    a_hyst_write: assert property (p_hyst_write) else $error("Hysteresis bits miss write.");

    property p_gate_blocks;
        ##0 p3_gpio_in == (p3_pad_in & gate_reg[3:0]);
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("Port 3 input not gated.");

    property p_p0_roundtrip;
        clk_en && reg_wr && reg_addr == `ADDR_P0_SEL ##1 clk_en && reg_rd && reg_addr == `ADDR_P0_SEL
            |=> reg_rdata == ($past(reg_wdata, 2) & `MASK_P0_SEL);
    endproperty
    a_p0_roundtrip: assert property (p_p0_roundtrip) else $error("Port 0 select readback wrong.");

    property p_timer4n_route;
        p0_sel_reg[5] |-> p0_pad_out[5] == timer_ch4_inverted_out && p0_pad_oe[5];
    endproperty
    a_timer4n_route: assert property (p_timer4n_route) else $error("Timer 4 inverted not on pin.");

    property p_gpio_keeps_pin;
        !p1_sel_reg[6] |-> p1_pad_out[6] == p1_gpio_out[6] && p1_pad_oe[6] == p1_gpio_oe[6];
    endproperty
    a_gpio_keeps_pin: assert property (p_gpio_keeps_pin) else $error("Port 1 pin 6 not port.");

    property p_clock_out1;
        p1_sel_reg[3] |-> p1_pad_out[3] == clock_out_ch1 && p1_pad_oe[3];
    endproperty
    a_clock_out1: assert property (p_clock_out1) else $error("Clock output 1 not on pin.");

    property p_spi_data_in;
        p2_sel_reg[0] |-> spi_data_in == p2_pad_in[0];
    endproperty
    a_spi_data_in: assert property (p_spi_data_in) else $error("SPI data input not routed.");

    property p_debug_default;
        !p3_sel_reg[3] |-> p3_pad_out[3] == debug_serial_io_drv && p3_pad_oe[3] == debug_serial_io_oe;
    endproperty
    a_debug_default: assert property (p_debug_default) else $error("Debug data not on pin 3.");

    property p_p3_sel_read;
        clk_en && reg_rd && reg_addr == `ADDR_P3_SEL |=> reg_rdata[7:4] == 4'h0 && reg_rdata[0] == p3_sel_reg[0];
    endproperty
    a_p3_sel_read: assert property (p_p3_sel_read) else $error("Port 3 select readback wrong.");

    // Main scenarios.
    c_spi_selected: cover property (p2_sel_reg[2:0] == 3'h7);
    c_debug_released: cover property (p3_sel_reg[3:1] == 3'h7);
    c_write_read: cover property (reg_wr ##1 reg_rd);
endmodule

// [pad_partner.sv]
module pad_partner #(
    parameter int WIDTH = 28
) (
    input wire logic [WIDTH-1:0] pad_out, // Level the block drives.
    input wire logic [WIDTH-1:0] pad_oe, // Drive enable from the block.
    input wire logic [WIDTH-1:0] ext_level, // Level of the outside world.
    output logic [WIDTH-1:0] pad_in // Resolved pad level.
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pad follows the block, a released one shows the changing outside level.
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// [port_pin_function_mux_tb_top.sv]
`include "port_mux_consts.svh"
module port_pin_function_mux_tb_top;
    import port_mux_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    addr_type reg_addr = '0;
    byte_type reg_wdata = '0, reg_rdata;
    wire logic [27:0] pout, poe, pad, gin;
    logic [27:0] gout = '0, goe = '0, ext = '0;
    logic [25:0] pv = '0;
    wire logic [12:0] pi;
    wire logic [3:0] schm;
    byte_type rm [6];
    int num_errors = 0, checked = 0;
    localparam addr_type ADDRS [6] = '{`ADDR_P3_HYST, `ADDR_P3_GATE, `ADDR_P0_SEL, `ADDR_P1_SEL, `ADDR_P2_SEL,
        `ADDR_P3_SEL};
    localparam byte_type MASKS [6] = '{`MASK_P3, `MASK_P3, `MASK_P0_SEL, `MASK_FULL, `MASK_FULL, `MASK_P3};
    localparam int BIT_OF [13] = '{2, 8, 19, 16, 25, 14, 15, 13, 12, 10, 21, 18, 27};
    ////////////////////////////////////////////////////////////////////////////////
    port_pin_function_mux port_pin_function_mux_i (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .p0_pad_in(pad[7:0]), .p0_pad_out(pout[7:0]), .p0_pad_oe(poe[7:0]), .p0_gpio_out(gout[7:0]),
        .p0_gpio_oe(goe[7:0]), .p0_gpio_in(gin[7:0]), .p1_pad_in(pad[15:8]), .p1_pad_out(pout[15:8]),
        .p1_pad_oe(poe[15:8]), .p1_gpio_out(gout[15:8]), .p1_gpio_oe(goe[15:8]), .p1_gpio_in(gin[15:8]),
        .p2_pad_in(pad[23:16]), .p2_pad_out(pout[23:16]), .p2_pad_oe(poe[23:16]), .p2_gpio_out(gout[23:16]),
        .p2_gpio_oe(goe[23:16]), .p2_gpio_in(gin[23:16]), .p3_pad_in(pad[27:24]), .p3_pad_out(pout[27:24]),
        .p3_pad_oe(poe[27:24]), .p3_gpio_out(gout[27:24]), .p3_gpio_oe(goe[27:24]), .p3_gpio_in(gin[27:24]),
        .p3_schmitt_en(schm), .timer_ch4_inverted_out(pv[0]), .timer_ch4_out(pv[1]), .remote_tx_out(pv[2]),
        .remote_rx_in(pi[0]), .spi_slave_select_n_drv(pv[3]), .spi_slave_select_n_oe(pv[4]),
        .spi_slave_select_n(pi[6]), .timer_ch5_out(pv[5]), .external_clock_in_0(pi[5]), .i2c_scl_drv(pv[6]),
        .i2c_scl_oe(pv[7]), .i2c_scl_in(pi[7]), .i2c_sda_drv(pv[8]), .i2c_sda_oe(pv[9]), .i2c_sda_in(pi[8]),
        .clock_out_ch1(pv[10]), .serial1_clock_drv(pv[11]), .serial1_clock_oe(pv[12]), .serial1_clock(pi[9]),
        .serial1_tx(pv[13]), .serial1_rx(pi[1]), .timer_ch3_inverted_out(pv[14]), .timer_ch3_out(pv[15]),
        .serial0_clock_drv(pv[16]), .serial0_clock_oe(pv[17]), .serial0_clock(pi[10]), .serial0_tx(pv[18]),
        .serial0_rx(pi[2]), .spi_serial_clock_drv(pv[19]), .spi_serial_clock_oe(pv[20]), .spi_serial_clock(pi[11]),
        .spi_data_out(pv[21]), .spi_data_in(pi[3]), .debug_serial_io_drv(pv[22]), .debug_serial_io_oe(pv[23]),
        .debug_serial_io(pi[12]), .debug_status(pv[24]), .high_speed_clock_out(pv[25]), .debug_clock(pi[4]));
    pad_partner pad_partner_i (.pad_out(pout), .pad_oe(poe), .ext_level(ext), .pad_in(pad));
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running system clock.
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk_reg(input string what, input byte_type exp, input byte_type got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chk_pin(input string what, input logic [27:0] exp, input logic [27:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input int k, input byte_type d, input logic en);
        @(posedge clk_sys);
        reg_addr <= ADDRS[k];
        reg_wdata <= d;
        reg_wr <= 1'b1;
        clk_en <= en;
        if (en) rm[k] = d & MASKS[k];
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        clk_en <= 1'b1;
    endtask
    task automatic rd(input addr_type a, input byte_type exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk_reg("register read", exp, reg_rdata);
    endtask
    // Writes one register and reads it back in the very next cycle, with no gap.
    task automatic wr_rd(input int k, input byte_type d);
        @(posedge clk_sys);
        reg_addr <= ADDRS[k];
        reg_wdata <= d;
        reg_wr <= 1'b1;
        rm[k] = d & MASKS[k];
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk_reg("back-to-back read", rm[k], reg_rdata);
    endtask
    // Works out every pad and peripheral level from the register model and the stimulus.
    task automatic check_pins();
        logic [27:0] own, po, pe, eoe, eout, epad;
        logic [12:0] ei;
        own = {~rm[5][3:1], rm[5][0], rm[4], rm[3], rm[2]};
        po = {pv[22], pv[24], 1'b0, pv[25], pv[14], pv[15], pv[16], pv[18], 1'b0, pv[19], pv[21], 1'b0, pv[3],
            pv[5], pv[6], pv[8], pv[10], pv[11], pv[13], 1'b0, 2'b0, pv[0], pv[1], pv[2], 3'b0};
        pe = {pv[23], 3'b101, 2'b11, pv[17], 2'b10, pv[20], 2'b10, pv[4], 1'b1, pv[7], pv[9], 1'b1, pv[12], 2'b10,
            8'h38};
        eoe = (own & pe) | (~own & goe);
        eout = (own & po) | (~own & gout);
        epad = (eoe & eout) | (~eoe & ext);
        epad[27:24] = epad[27:24] & rm[1][3:0];
        for (int i = 0; i < 13; i++) ei[i] = own[BIT_OF[i]] ? epad[BIT_OF[i]] : (i inside {6, 7, 8});
        ei[5] = own[14] ? 1'b0 : epad[14];
        chk_pin("pad enable", eoe, poe);
        chk_pin("pad drive", eout, pout);
        chk_pin("port input", epad, gin);
        chk_pin("peripheral input", {15'h0, ei}, {15'h0, pi});
        chk_reg("schmitt select", {4'h0, rm[0][3:0]}, {4'h0, schm});
    endtask
    // Holds reset for three cycles, then reads every register back.
    task automatic do_reset();
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int k = 0; k < 6; k++) rm[k] = (k == 0 ? `RST_P3_HYST : k == 1 ? `RST_P3_GATE : `RST_SEL) & MASKS[k];
        for (int k = 0; k < 6; k++) rd(ADDRS[k], rm[k]);
        check_pins();
    endtask
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, random selects with frozen writes, pin checks, reset at the end of the run.
    initial begin
        void'($urandom(32'hd452));
        do_reset();
        rd(16'h52a4, 8'h00);
        for (int n = 0; n < 60; n++) begin
            for (int k = 0; k < 6; k++)
                wr(k, n == 0 ? 8'hff : n == 1 ? 8'h00 : 8'($urandom), n < 4 || $urandom_range(3) != 0);
            for (int k = 0; k < 6; k++) rd(ADDRS[k], rm[k]);
            wr_rd(n % 6, 8'($urandom));
            @(posedge clk_sys);
            pv <= 26'($urandom);
            gout <= 28'($urandom);
            goe <= 28'($urandom);
            ext <= 28'($urandom);
            #1;
            check_pins();
        end
        @(posedge clk_sys);
        resetn <= 1'b0;
        do_reset();
        give_verdict();
    end
    // Cuts the run short if the sequence hangs.
    initial begin
        repeat (50000) @(posedge clk_sys);
        num_errors++;
        give_verdict();
    end
endmodule
